// file: dcc_defines.svh
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Register byte addresses
`define DCC_ADDR_CTRL      12'h000
`define DCC_ADDR_FLAG      12'h004
`define DCC_ADDR_IRQEN     12'h008
`define DCC_ADDR_PORT      12'h00c

// Control register fields
`define DCC_BIT_TWO_RES    7
`define DCC_BIT_ONE_RES    6
`define DCC_BIT_TWO_INV    5
`define DCC_BIT_ONE_INV    4
`define DCC_BIT_SWITCH     3
`define DCC_CTRL_WMASK     8'h3f
`define DCC_CTRL_RESET     8'h07

// Flag register: change flag at bit 6
`define DCC_BIT_FLAG       6
// Irq enable register: global 7, peripheral 6, change 0
`define DCC_BIT_GIE        7
`define DCC_BIT_PERIPHERAL_IRQ_ENABLE       6
`define DCC_BIT_CHANGE_IRQ_ENABLE       0

// Port register fields
`define DCC_PORT_CFG_LSB   8
`define DCC_PORT_CFG_RESET 4'h0
`define DCC_PORT_DIR_RESET 2'h3
`define DCC_ANALOG_CFG_MAX 4'h7

`endif

// file: dcc_pkg.sv
package dcc_pkg;
	typedef enum logic [2:0] {
		DCC_M_RESET   = 3'b000,
		DCC_M_ONE_IND = 3'b001,
		DCC_M_TWO_IND = 3'b010,
		DCC_M_TWO_OUT = 3'b011,
		DCC_M_TWO_COM = 3'b100,
		DCC_M_COM_OUT = 3'b101,
		DCC_M_FOUR_MX = 3'b110,
		DCC_M_OFF     = 3'b111
	} dcc_mode_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic       flag;
		logic [2:0] irq_en;
		logic [3:0] port_cfg;
		logic [1:0] port_dir;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] latched;
		logic [31:0] prdata;
		logic       pready;
		logic       pslverr;
		logic       irq;
		logic       wake;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [3:0] route;
	} dcc_state_t;
endpackage

// file: dcc_control.sv
`include "dcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dcc_control (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmp_one_above,
	input  wire logic        cmp_two_above,
	input  wire logic        sleep_mode,
	input  wire logic [1:0]  port_pin_in,
	output logic             irq_req,
	output logic             wake_req,
	output logic [1:0]       out_pin_o,
	output logic [1:0]       out_pin_oe,
	output logic [3:0]       input_route,
	output logic [7:0]       cmp_power_mode
);
	import dcc_pkg::*;

	dcc_state_t      s_q;
	dcc_state_t      s_d;
	wire logic [1:0] res_raw;
	wire logic [1:0] res_out;
	wire logic [1:0] diff;
	wire logic [1:0] port_view;
	logic            mismatch;
	logic            acc;
	logic            wr;
	logic            rd;
	logic            ctrl_acc;
	logic            sel_ctrl;
	logic            sel_flag;
	logic            sel_irqen;
	logic            sel_port;
	logic            sel_none;
	logic            we_ctrl;
	logic            we_flag;
	logic            on;
	logic [7:0]      ctrl_nx;
	dcc_mode_t       mode;
	dcc_mode_t       mode_nx;
	logic            pin_en;
	logic            ref_plus;
	logic            alt_minus;
	logic            one_on;
	logic            two_on;
	logic            analog_cfg;
	logic            flag_hw_set;
	logic            flag_sw_set;
	logic            flag_sw_clr;
	logic            flag_nx;
	logic [31:0]     rd_word;

	////////////////////////////////////////////////////////////////////////
	// Result path
	assign mode     = dcc_mode_t'(s_q.ctrl[2:0]);
	assign on       = (mode != DCC_M_OFF);
	assign mismatch = |diff;

	// One slice per comparator
	for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
		logic inv_bit;
		logic polar;
		assign inv_bit     = s_q.ctrl[`DCC_BIT_ONE_INV+ch];
		assign res_raw[ch] = (ch == 0) ? cmp_one_above : cmp_two_above;
		assign polar       = res_raw[ch] ^ inv_bit;
		assign res_out[ch] = on && polar;
		assign diff[ch]    = s_q.sync2[ch] ^ s_q.latched[ch];
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign acc       = psel && penable && !s_q.pready;
	assign wr        = acc && pwrite;
	assign rd        = acc && !pwrite;
	assign sel_ctrl  = (paddr == `DCC_ADDR_CTRL);
	assign sel_flag  = (paddr == `DCC_ADDR_FLAG);
	assign sel_irqen = (paddr == `DCC_ADDR_IRQEN);
	assign sel_port  = (paddr == `DCC_ADDR_PORT);
	assign sel_none  = !(sel_ctrl || sel_flag || sel_irqen || sel_port);
	assign ctrl_acc  = acc && sel_ctrl;
	assign we_ctrl   = wr && sel_ctrl && pstrb[0];
	assign we_flag   = wr && sel_flag && pstrb[0];

	// Control word as it stands after this cycle; bits 7:6 never written
	assign ctrl_nx = we_ctrl
		? ((s_q.ctrl & ~`DCC_CTRL_WMASK) | (pwdata[7:0] & `DCC_CTRL_WMASK))
		: s_q.ctrl;
	assign mode_nx = dcc_mode_t'(ctrl_nx[2:0]);

	////////////////////////////////////////////////////////////////////////
	// Flag causes; a hardware set outranks a software clear
	assign flag_hw_set = mismatch;
	assign flag_sw_set = we_flag && pwdata[`DCC_BIT_FLAG];
	assign flag_sw_clr = we_flag && !pwdata[`DCC_BIT_FLAG];
	assign flag_nx     = flag_hw_set || flag_sw_set || (s_q.flag && !flag_sw_clr);

	////////////////////////////////////////////////////////////////////////
	// Port pins as software sees them; analog pins read zero
	assign analog_cfg = (s_q.port_cfg <= `DCC_ANALOG_CFG_MAX);
	for (genvar pn = 0; pn < 2; pn++) begin : g_pin
		assign port_view[pn] = analog_cfg ? 1'b0 : port_pin_in[pn];
	end

	////////////////////////////////////////////////////////////////////////
	// Mode decode for the coming configuration
	always_comb begin
		pin_en    = 1'b0;
		ref_plus  = 1'b0;
		alt_minus = 1'b0;
		one_on    = 1'b0;
		two_on    = 1'b0;
		case (mode_nx)
			DCC_M_RESET: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b1;
				two_on    = 1'b1;
			end
			DCC_M_ONE_IND: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b0;
				two_on    = 1'b1;
			end
			DCC_M_TWO_IND: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b1;
				two_on    = 1'b1;
			end
			DCC_M_TWO_OUT: begin
				pin_en    = 1'b1;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b1;
				two_on    = 1'b1;
			end
			DCC_M_TWO_COM: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b1;
				two_on    = 1'b1;
			end
			DCC_M_COM_OUT: begin
				pin_en    = 1'b1;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b1;
				two_on    = 1'b1;
			end
			DCC_M_FOUR_MX: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b1;
				alt_minus = ctrl_nx[`DCC_BIT_SWITCH];
				one_on    = 1'b1;
				two_on    = 1'b1;
			end
			DCC_M_OFF: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b0;
				two_on    = 1'b0;
			end
			default: begin
				pin_en    = 1'b0;
				ref_plus  = 1'b0;
				alt_minus = 1'b0;
				one_on    = 1'b0;
				two_on    = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Read word assembly
	always_comb begin
		rd_word = 32'h0;
		if (sel_ctrl) begin
			rd_word[`DCC_BIT_TWO_RES] = s_q.sync2[1];
			rd_word[`DCC_BIT_ONE_RES] = s_q.sync2[0];
			rd_word[5:0]              = s_q.ctrl[5:0];
		end
		if (sel_flag) begin
			rd_word[`DCC_BIT_FLAG] = s_q.flag;
		end
		if (sel_irqen) begin
			rd_word[`DCC_BIT_GIE]  = s_q.irq_en[2];
			rd_word[`DCC_BIT_PERIPHERAL_IRQ_ENABLE] = s_q.irq_en[1];
			rd_word[`DCC_BIT_CHANGE_IRQ_ENABLE] = s_q.irq_en[0];
		end
		if (sel_port) begin
			rd_word[2:1]  = port_view;
			rd_word[11:8] = s_q.port_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.pready  = acc;
		s_d.pslverr = 1'b0;
		s_d.prdata  = 32'h0;
		// Two-stage synchroniser for change detection
		s_d.sync1 = res_out;
		s_d.sync2 = s_q.sync1;
		// Mismatch re-sets the flag every clock
		s_d.flag = flag_nx;
		if (ctrl_acc) begin
			s_d.latched = s_q.sync2;
		end
		if (wr) begin
			case (paddr)
				`DCC_ADDR_CTRL: begin
					if (pstrb[0]) begin
						s_d.ctrl = (s_q.ctrl & ~`DCC_CTRL_WMASK)
							| (pwdata[7:0] & `DCC_CTRL_WMASK);
					end
				end
				`DCC_ADDR_FLAG: begin
					s_d.flag = flag_nx;
				end
				`DCC_ADDR_IRQEN: begin
					if (pstrb[0]) begin
						s_d.irq_en = {pwdata[`DCC_BIT_GIE], pwdata[`DCC_BIT_PERIPHERAL_IRQ_ENABLE],
							pwdata[`DCC_BIT_CHANGE_IRQ_ENABLE]};
					end
				end
				`DCC_ADDR_PORT: begin
					if (pstrb[0]) begin
						s_d.port_dir = pwdata[2:1];
					end
					if (pstrb[1]) begin
						s_d.port_cfg = pwdata[`DCC_PORT_CFG_LSB+3:`DCC_PORT_CFG_LSB];
					end
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end
		if (rd) begin
			s_d.prdata  = rd_word;
			s_d.pslverr = sel_none;
		end
		// Request gating; flag sets regardless, sleep does not stop it
		s_d.irq  = s_d.flag && (&s_d.irq_en);
		s_d.wake = sleep_mode && s_d.flag && s_d.irq_en[0];
		// Pin output only in output modes
		s_d.pin_out = pin_en ? res_out : 2'h0;
		s_d.pin_oe  = pin_en ? ~s_q.port_dir : 2'h0;
		// Input routing: {plus_ref, minus_alt, one_on, two_on}
		s_d.route = {ref_plus, alt_minus, one_on, two_on};
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q          <= '0;
			s_q.ctrl     <= `DCC_CTRL_RESET;
			s_q.port_cfg <= `DCC_PORT_CFG_RESET;
			s_q.port_dir <= `DCC_PORT_DIR_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata         = s_q.prdata;
	assign pready         = s_q.pready;
	assign pslverr        = s_q.pslverr;
	assign irq_req        = s_q.irq;
	assign wake_req       = s_q.wake;
	assign out_pin_o      = s_q.pin_out;
	assign out_pin_oe     = s_q.pin_oe;
	assign input_route    = s_q.route;
	assign cmp_power_mode = {5'h0, s_q.ctrl[2:0]};
endmodule

`default_nettype wire

// file: dcc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_props (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sleep_mode,
	input wire logic        wake_req,
	input wire logic [1:0]  out_pin_o,
	input wire logic [1:0]  out_pin_oe,
	input wire logic [7:0]  cmp_power_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic [2:0] md = cmp_power_mode[2:0];
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("access not answered");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_bad; pready && paddr > 12'h00c |-> pslverr; endproperty
	a_bad: assert property (p_bad) else $error("unmapped not refused");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_oe; out_pin_oe != 2'h0 |-> md == 3'h3 || md == 3'h5; endproperty
	a_oe: assert property (p_oe) else $error("pin enabled in wrong mode");
	property p_pin; out_pin_o != 2'h0 |-> md == 3'h3 || md == 3'h5; endproperty
	a_pin: assert property (p_pin) else $error("pin driven in wrong mode");
	property p_wake; wake_req |-> $past(sleep_mode); endproperty
	a_wake: assert property (p_wake) else $error("wake while awake");
	property p_pwr; cmp_power_mode[7:3] == 5'h0; endproperty
	a_pwr: assert property (p_pwr) else $error("mode out of range");
endmodule
bind dcc_control dcc_props u_props (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.sleep_mode(sleep_mode), .wake_req(wake_req), .out_pin_o(out_pin_o),
	.out_pin_oe(out_pin_oe), .cmp_power_mode(cmp_power_mode));
`default_nettype wire

// file: dcc_analog.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_analog (
	input  wire logic [7:0] lvl_plus,
	input  wire logic [7:0] lvl_minus_one,
	input  wire logic [7:0] lvl_minus_two,
	input  wire logic [1:0] pin_o,
	input  wire logic [1:0] pin_oe,
	output logic            above_one,
	output logic            above_two,
	output logic [1:0]      pin_in
);
	assign above_one = lvl_plus > lvl_minus_one;
	assign above_two = lvl_plus > lvl_minus_two;
	// Undriven pins pulled low
	assign pin_in = pin_o & pin_oe;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, irq_req, wake_req, c1, c2, er;
	logic [3:0]  rt;
	logic [1:0]  pin_in, pin_o, pin_oe;
	logic [7:0]  lp = 8'h64, m1 = 8'h32, m2 = 8'h96, pm;
	int          err_total = 0, compares = 0;
	always #50 core_clk = ~core_clk;
	dcc_analog fe (.lvl_plus(lp), .lvl_minus_one(m1), .lvl_minus_two(m2), .pin_o(pin_o),
		.pin_oe(pin_oe), .above_one(c1), .above_two(c2), .pin_in(pin_in));
	dcc_control dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_one_above(c1), .cmp_two_above(c2),
		.sleep_mode(sleep_mode), .port_pin_in(pin_in), .irq_req(irq_req),
		.wake_req(wake_req), .out_pin_o(pin_o), .out_pin_oe(pin_oe), .input_route(rt),
		.cmp_power_mode(pm));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk) penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task complete_run;
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdc(12'h000, 32'h07);
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, 12'h000, 32'(m));
			@(posedge core_clk);
			chk(pm, 32'(m));
		end
		apb(1'b1, 12'h000, 32'hff);
		rdc(12'h000, 32'h3f);
		apb(1'b1, 12'h000, 32'h06);
		repeat (6) @(posedge core_clk);
		rdc(12'h000, 32'h46);
		chk(rt, 32'hb);
		chk(er, 32'h0);
		apb(1'b1, 12'h000, 32'h0e);
		@(posedge core_clk);
		chk(rt, 32'hf);
		apb(1'b1, 12'h000, 32'h36);
		repeat (6) @(posedge core_clk);
		rdc(12'h000, 32'hb6);
		apb(1'b1, 12'h004, 32'h0);
		rdc(12'h004, 32'h0);
		m2 <= 8'h32;
		repeat (6) @(posedge core_clk);
		rdc(12'h004, 32'h40);
		apb(1'b1, 12'h004, 32'h0);
		rdc(12'h004, 32'h40);
		rdc(12'h000, 32'h36);
		apb(1'b1, 12'h004, 32'h0);
		rdc(12'h004, 32'h0);
		apb(1'b1, 12'h004, 32'h40);
		rdc(12'h004, 32'h40);
		apb(1'b1, 12'h008, 32'hc1);
		@(posedge core_clk);
		chk(irq_req, 32'h1);
		apb(1'b1, 12'h008, 32'h81);
		@(posedge core_clk);
		chk(irq_req, 32'h0);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(wake_req, 32'h1);
		sleep_mode <= 1'b0;
		rdc(12'h000, 32'h36);
		apb(1'b1, 12'h00c, 32'hf00);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h000, 32'h03);
		repeat (2) @(posedge core_clk);
		chk(pin_oe, 32'h3);
		chk(pin_o, 32'h3);
		chk(rt, 32'h3);
		chk(irq_req, 32'h0);
		rdc(12'h00c, 32'hf06);
		apb(1'b1, 12'h00c, 32'h000);
		rdc(12'h00c, 32'h000);
		apb(1'b0, 12'h010, 32'h0);
		chk(er, 32'h1);
		complete_run;
	end
	initial begin
		#400000;
		err_total++;
		complete_run;
	end
endmodule
`default_nettype wire
